// *** core/bmc_core.sv ***
// Battery monitor digital core: converter sequencer, charge counter, limits, serial slave
`timescale 1ns/1ps
module bmc_core #(
  parameter int CONV_CYC = bmc_pkg::CONV_CYCLES,
  parameter int IDLE_CYC = bmc_pkg::SCAN_IDLE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        alert_or_full_pin_in,
  output logic             alert_or_full_pin_out,
  output logic             alert_or_full_pin_oe,
  input  wire logic [13:0] volt_code,
  input  wire logic [9:0]  temp_code,
  input  wire logic        charge_up,
  input  wire logic        charge_down,
  output logic             analog_off
);
  import bmc_pkg::*;

  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_PTR, L_WR, L_RD, L_ARA} bmc_link_e;
  typedef enum logic [1:0] {A_SLEEP, A_VOLT, A_TEMP, A_WAIT} bmc_adc_e;

  function automatic logic beyond(input logic [15:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
    beyond = (v > hi) || (v < lo);
  endfunction : beyond

  // Link side, clocked by the bus clock and data lines
  logic        start_tgl;
  logic        rs_tgl;
  logic        stop_tgl;
  logic        start_seen;
  bmc_link_e   link;
  logic [3:0]  bitc;
  logic [7:0]  sh;
  logic        ack_now;
  logic [7:0]  ptr;
  logic [7:0]  tx;
  bmc_wr_s     wr_q;
  logic        wr_tgl;
  logic        ara_tgl;
  logic [7:0]  rx_byte;
  // Snapshot of the map, frozen while the bus is busy
  logic [7:0]  snap [16];
  logic        snap_alert;

  function automatic logic [7:0] byte_at(input logic [7:0] p);
    byte_at = (p[7:4] == 4'h0) ? snap[p[3:0]] : 8'h00;
  endfunction : byte_at

  assign rx_byte = {sh[6:0], sda_in};

  // Repeated starts toggle their own flag, so the bus stays busy until the stop
  always_ff @(negedge sda_in or negedge nrst)
    if (!nrst)
    begin
      start_tgl <= 1'b0;
      rs_tgl    <= 1'b0;
    end
    else if (scl && start_tgl == stop_tgl)
      start_tgl <= ~start_tgl;
    else if (scl)
      rs_tgl <= ~rs_tgl;

  always_ff @(posedge sda_in or negedge nrst)
    if (!nrst)
      stop_tgl <= 1'b0;
    else if (scl)
      stop_tgl <= start_tgl;

  always_ff @(posedge scl or negedge nrst)
    if (!nrst)
    begin
      start_seen <= 1'b0;
      link       <= L_IDLE;
      bitc       <= 4'h0;
      sh         <= 8'h00;
      ack_now    <= 1'b0;
      ptr        <= 8'h00;
      tx         <= 8'h00;
      wr_q       <= '0;
      wr_tgl     <= 1'b0;
      ara_tgl    <= 1'b0;
    end
    else if ((start_tgl ^ rs_tgl) != start_seen)
    begin
      // First address bit; a repeated start restarts the same way
      start_seen <= start_tgl ^ rs_tgl;
      link       <= L_ADDR;
      bitc       <= 4'h1;
      sh         <= {7'h00, sda_in};
      ack_now    <= 1'b0;
    end
    else if (link != L_IDLE)
    begin
      if (bitc == 4'h8)
      begin
        bitc    <= 4'h0;
        ack_now <= 1'b0;
        if (link == L_RD && !ack_now)
        begin
          if (sda_in)
            link <= L_IDLE;
          else
          begin
            ptr <= ptr + 8'h01;
            tx  <= byte_at(ptr + 8'h01);
          end
        end
      end
      else
      begin
        bitc <= bitc + 4'h1;
        sh   <= rx_byte;
        if (link == L_ARA && tx[~bitc[2:0]] && !sda_in)
          link <= L_IDLE;
        else if (bitc == 4'h7)
        begin
          case (link)
            L_ADDR:
            begin
              if (rx_byte[7:1] == DEV_ADDR)
              begin
                ack_now <= 1'b1;
                link    <= rx_byte[0] ? L_RD : L_PTR;
                tx      <= byte_at(ptr);
              end
              else if (rx_byte[7:1] == ARA_ADDR && rx_byte[0] && snap_alert)
              begin
                ack_now <= 1'b1;
                link    <= L_ARA;
                tx      <= ARA_REPLY;
              end
              else
                link <= L_IDLE;
            end
            L_PTR:
            begin
              ptr     <= rx_byte;
              ack_now <= 1'b1;
              link    <= L_WR;
            end
            L_WR:
            begin
              wr_q    <= '{addr: ptr, data: rx_byte};
              wr_tgl  <= ~wr_tgl;
              ptr     <= ptr + 8'h01;
              ack_now <= 1'b1;
            end
            L_ARA:
            begin
              ara_tgl <= ~ara_tgl;
              link    <= L_IDLE;
            end
            default:
              ack_now <= 1'b0;
          endcase
        end
      end
    end

  // Data changes only after the falling clock edge; the line is only ever pulled low
  always_ff @(negedge scl or negedge nrst)
    if (!nrst)
    begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      sda_oe  <= (bitc == 4'h8 && ack_now) ||
                 ((link == L_RD || link == L_ARA) && bitc < 4'h8 && !tx[~bitc[2:0]]);
    end

  // Main clock side: crossings
  logic [3:0]  sy1;
  logic [3:0]  sy2;
  logic [1:0]  ev_last;
  logic        wr_ev;
  logic        ara_ev;
  logic        busy_s;
  logic        pin_s;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      sy1     <= 4'h0;
      sy2     <= 4'h0;
      ev_last <= 2'h0;
    end
    else if (ce)
    begin
      sy1     <= {alert_or_full_pin_in, start_tgl ^ stop_tgl, ara_tgl, wr_tgl};
      sy2     <= sy1;
      ev_last <= sy2[1:0];
    end

  assign wr_ev  = ce && (sy2[0] != ev_last[0]);
  assign ara_ev = ce && (sy2[1] != ev_last[1]);
  assign busy_s = sy2[2];
  assign pin_s  = sy2[3];

  // Registers
  bmc_ctrl_s   ctrl;
  logic [7:0]  status;
  logic [15:0] acc;
  logic [15:0] chg_hi;
  logic [15:0] chg_lo;
  logic [15:0] volt;
  logic [15:0] temp;
  logic [7:0]  v_hi;
  logic [7:0]  v_lo;
  logic [7:0]  t_hi;
  logic [7:0]  t_lo;
  bmc_adc_e    adc;
  logic [25:0] tmr;
  logic        conv_end;
  logic [6:0]  sub;
  logic [6:0]  sub_mask;
  logic        acc_inc;
  logic        acc_dec;
  logic [7:0]  set_bits;
  logic        alert_act;
  logic [7:0]  regmap [16];

  assign conv_end = ce && !ctrl.shdn && (adc == A_VOLT || adc == A_TEMP) &&
                    (tmr == 26'(CONV_CYC - 1));
  assign analog_off = ctrl.shdn;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      ctrl <= CTRL_RESET;
    else if (wr_ev && wr_q.addr == REG_CONTROL)
      ctrl <= wr_q.data;
    else if (conv_end && ctrl.mode == (adc == A_VOLT ? MODE_VOLT : MODE_TEMP))
      ctrl.mode <= MODE_SLEEP;

  // Converter sequencer; a running conversion always completes first
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      adc <= A_SLEEP;
      tmr <= '0;
    end
    else if (ce && !ctrl.shdn)
    begin
      case (adc)
        A_SLEEP:
        begin
          tmr <= '0;
          if (ctrl.mode == MODE_VOLT || ctrl.mode == MODE_AUTO)
            adc <= A_VOLT;
          else if (ctrl.mode == MODE_TEMP)
            adc <= A_TEMP;
        end
        A_VOLT, A_TEMP:
        begin
          if (conv_end)
          begin
            tmr <= '0;
            if (ctrl.mode == MODE_AUTO)
              adc <= (adc == A_VOLT) ? A_TEMP : A_WAIT;
            else
              adc <= A_SLEEP;
          end
          else
            tmr <= tmr + 26'h1;
        end
        A_WAIT:
        begin
          if (ctrl.mode != MODE_AUTO)
            adc <= A_SLEEP;
          else if (tmr == 26'(IDLE_CYC - 1))
          begin
            tmr <= '0;
            adc <= A_VOLT;
          end
          else
            tmr <= tmr + 26'h1;
        end
        default:
          adc <= A_SLEEP;
      endcase
    end

  // Results are left aligned; the code scales linearly to 6 V and 600 K
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      volt <= 16'h0000;
      temp <= 16'h0000;
    end
    else if (conv_end)
    begin
      if (adc == A_VOLT)
        volt <= {volt_code, 2'h0};
      else
        temp <= {temp_code, 6'h00};
    end

  // Limit registers
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      chg_hi <= LIM_HI_RESET;
      chg_lo <= LIM_LO_RESET;
      v_hi   <= LIM_HI_RESET[7:0];
      v_lo   <= LIM_LO_RESET[7:0];
      t_hi   <= LIM_HI_RESET[7:0];
      t_lo   <= LIM_LO_RESET[7:0];
    end
    else if (wr_ev)
    begin
      if (wr_q.addr == REG_CUP_HI)
        chg_hi[15:8] <= wr_q.data;
      else if (wr_q.addr == REG_CUP_LO)
        chg_hi[7:0] <= wr_q.data;
      else if (wr_q.addr == REG_CLO_HI)
        chg_lo[15:8] <= wr_q.data;
      else if (wr_q.addr == REG_CLO_LO)
        chg_lo[7:0] <= wr_q.data;
      else if (wr_q.addr == REG_VUP)
        v_hi <= wr_q.data;
      else if (wr_q.addr == REG_VLO)
        v_lo <= wr_q.data;
      else if (wr_q.addr == REG_TUP)
        t_hi <= wr_q.data;
      else if (wr_q.addr == REG_TLO)
        t_lo <= wr_q.data;
    end

  // Coulomb counter with prescaler M = 2**presc
  assign sub_mask = 7'((8'h01 << ctrl.presc) - 8'h01);
  assign acc_inc  = ce && !ctrl.shdn && charge_up && !charge_down && sub == sub_mask;
  assign acc_dec  = ce && !ctrl.shdn && charge_down && !charge_up && sub == 7'h00;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      sub <= 7'h00;
    else if (ce)
    begin
      if (ctrl.shdn)
        sub <= 7'h00;
      else if (charge_up && !charge_down)
        sub <= (sub >= sub_mask) ? 7'h00 : sub + 7'h01;
      else if (charge_down && !charge_up)
        sub <= (sub == 7'h00) ? sub_mask : sub - 7'h01;
    end

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      acc <= ACC_RESET;
    else if (ce && ctrl.pin_cfg == PIN_CHG && pin_s)
      acc <= ACC_FULL;
    else if (wr_ev && wr_q.addr == REG_ACC_HI)
      acc[15:8] <= wr_q.data;
    else if (wr_ev && wr_q.addr == REG_ACC_LO)
      acc[7:0] <= wr_q.data;
    else if (acc_inc)
      acc <= acc + 16'h0001;
    else if (acc_dec)
      acc <= acc - 16'h0001;

  // Status flags: hardware set wins over a write-one-to-clear
  always_comb
  begin
    set_bits            = 8'h00;
    set_bits[ST_VOLT]   = conv_end && adc == A_VOLT &&
                          beyond({volt_code[13:6], 8'h00}, {v_lo, 8'h00}, {v_hi, 8'h00});
    set_bits[ST_TEMP]   = conv_end && adc == A_TEMP &&
                          beyond({temp_code[9:2], 8'h00}, {t_lo, 8'h00}, {t_hi, 8'h00});
    set_bits[ST_CHG_HI] = ce && acc > chg_hi;
    set_bits[ST_CHG_LO] = ce && acc < chg_lo;
    set_bits[ST_ACC_OV] = (acc_inc && acc == 16'hffff) || (acc_dec && acc == 16'h0000);
  end

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      status <= 8'h00;
    else if (wr_ev && wr_q.addr == REG_STATUS)
      status <= (status & ~wr_q.data) | set_bits;
    else
      status <= status | set_bits;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      alert_act             <= 1'b0;
      alert_or_full_pin_oe  <= 1'b0;
      alert_or_full_pin_out <= 1'b0;
    end
    else if (ce)
    begin
      if (ctrl.pin_cfg == PIN_ALERT && |(set_bits & ~status))
        alert_act <= 1'b1;
      else if (ara_ev || ctrl.pin_cfg != PIN_ALERT)
        alert_act <= 1'b0;
      alert_or_full_pin_oe  <= alert_act && ctrl.pin_cfg == PIN_ALERT;
      alert_or_full_pin_out <= 1'b0;
    end

  // Byte view of the map; writes to result bytes fall through and are ignored
  always_comb
  begin
    regmap[0]  = status;
    regmap[1]  = ctrl;
    regmap[2]  = acc[15:8];
    regmap[3]  = acc[7:0];
    regmap[4]  = chg_hi[15:8];
    regmap[5]  = chg_hi[7:0];
    regmap[6]  = chg_lo[15:8];
    regmap[7]  = chg_lo[7:0];
    regmap[8]  = volt[15:8];
    regmap[9]  = volt[7:0];
    regmap[10] = v_hi;
    regmap[11] = v_lo;
    regmap[12] = temp[15:8];
    regmap[13] = temp[7:0];
    regmap[14] = t_hi;
    regmap[15] = t_lo;
  end

  // The snapshot holds still for a whole transfer, so multi-byte reads are coherent
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      for (int i = 0; i < 16; i++)
        snap[i] <= 8'h00;
      snap_alert <= 1'b0;
    end
    else if (ce && !busy_s)
    begin
      for (int i = 0; i < 16; i++)
        snap[i] <= regmap[i];
      snap_alert <= alert_act && ctrl.pin_cfg == PIN_ALERT;
    end

  sleep_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    (adc == A_SLEEP && ctrl.mode == MODE_SLEEP) |=> adc == A_SLEEP)
    else $error("converter left sleep without a mode");
  single_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    (conv_end && adc == A_VOLT && ctrl.mode == MODE_VOLT && !wr_ev)
    |=> (ctrl.mode == MODE_SLEEP && adc == A_SLEEP))
    else $error("single conversion did not return to sleep");
  auto_next_a: assert property (@(posedge mclk) disable iff (!nrst)
    (conv_end && adc == A_VOLT && ctrl.mode == MODE_AUTO) |=> adc == A_TEMP)
    else $error("scan did not move to temperature");
  finish_first_a: assert property (@(posedge mclk) disable iff (!nrst)
    (adc == A_VOLT && !conv_end) |=> adc == A_VOLT)
    else $error("voltage conversion abandoned early");
  result_stable_a: assert property (@(posedge mclk) disable iff (!nrst)
    !conv_end |=> volt == $past(volt) && temp == $past(temp))
    else $error("result changed outside conversion end");
  full_load_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && ctrl.pin_cfg == PIN_CHG && pin_s) |=> acc == ACC_FULL)
    else $error("charge complete did not load full scale");
  volt_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
    (conv_end && adc == A_VOLT && volt_code[13:6] > v_hi) |=> status[ST_VOLT])
    else $error("voltage flag not set above limit");
  alert_pin_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && alert_act && ctrl.pin_cfg == PIN_ALERT) |=> alert_or_full_pin_oe)
    else $error("alert pin not pulled low");
endmodule : bmc_core

// *** core/bmc_pkg.sv ***
// Package: register map, field layout, reset values and timing of the battery monitor core
package bmc_pkg;
  // Bus addresses
  localparam logic [6:0] DEV_ADDR  = 7'h64;
  localparam logic [6:0] ARA_ADDR  = 7'h0c;
  localparam logic [7:0] ARA_REPLY = 8'hc9;
  // Register offsets
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h01;
  localparam logic [7:0] REG_ACC_HI  = 8'h02;
  localparam logic [7:0] REG_ACC_LO  = 8'h03;
  localparam logic [7:0] REG_CUP_HI  = 8'h04;
  localparam logic [7:0] REG_CUP_LO  = 8'h05;
  localparam logic [7:0] REG_CLO_HI  = 8'h06;
  localparam logic [7:0] REG_CLO_LO  = 8'h07;
  localparam logic [7:0] REG_VOLT_HI = 8'h08;
  localparam logic [7:0] REG_VOLT_LO = 8'h09;
  localparam logic [7:0] REG_VUP     = 8'h0a;
  localparam logic [7:0] REG_VLO     = 8'h0b;
  localparam logic [7:0] REG_TEMP_HI = 8'h0c;
  localparam logic [7:0] REG_TEMP_LO = 8'h0d;
  localparam logic [7:0] REG_TUP     = 8'h0e;
  localparam logic [7:0] REG_TLO     = 8'h0f;
  // Status bit positions
  localparam int ST_VOLT   = 1;
  localparam int ST_CHG_LO = 2;
  localparam int ST_CHG_HI = 3;
  localparam int ST_TEMP   = 4;
  localparam int ST_ACC_OV = 5;
  // Converter mode and pin role codes
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_TEMP  = 2'h1;
  localparam logic [1:0] MODE_VOLT  = 2'h2;
  localparam logic [1:0] MODE_AUTO  = 2'h3;
  localparam logic [1:0] PIN_OFF    = 2'h0;
  localparam logic [1:0] PIN_CHG    = 2'h1;
  localparam logic [1:0] PIN_ALERT  = 2'h2;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] presc;
    logic [1:0] pin_cfg;
    logic       shdn;
  } bmc_ctrl_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } bmc_wr_s;

  // Reset values and the charge-complete load value
  localparam bmc_ctrl_s  CTRL_RESET    = '{mode: 2'h0, presc: 3'h7, pin_cfg: 2'h2, shdn: 1'b0};
  localparam logic [15:0] ACC_RESET    = 16'h7fff;
  localparam logic [15:0] ACC_FULL     = 16'hffff;
  localparam logic [15:0] LIM_HI_RESET = 16'hffff;
  localparam logic [15:0] LIM_LO_RESET = 16'h0000;
  // Timing
  localparam int CLK_HZ           = 20000000;
  localparam int CONV_TIME_MS     = 10;
  localparam int SCAN_IDLE_MS     = 2000;
  localparam int CONV_CYCLES      = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int SCAN_IDLE_CYCLES = CLK_HZ / 1000 * SCAN_IDLE_MS;
endpackage : bmc_pkg

// *** tb/bmc_core_test.sv ***
// Self-checking bench of the battery monitor core
`timescale 1ns/1ps
module bmc_core_test;
  import bmc_pkg::*;
  localparam int CONV  = 20;
  localparam int IDLE  = 30;
  localparam int LIMIT = 20000;
  logic        mclk        = 1'b0;
  logic        nrst        = 1'b0;
  logic        full_lvl    = 1'b0;
  logic        ce          = 1'b1;
  logic        charge_up   = 1'b0;
  logic        charge_down = 1'b0;
  logic [13:0] volt_code   = 14'h0000;
  logic [9:0]  temp_code   = 10'h000;
  wire         scl, sda_rel, sda_line, sda_out, sda_oe;
  wire         pin_out, pin_oe, pin_line, analog_off;
  int          n_errors    = 0;
  int          compares    = 0;
  int          cycles      = 0;
  logic [7:0]  rx [16];
  logic [7:0]  b;
  logic        k;
  // Register values after reset, offsets 00 to 0f
  logic [7:0]  rows [16]   = '{8'h00, 8'h3c, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
  always #25 mclk = ~mclk;
  // Open-drain wires: low while a party pulls; otherwise sda_line is high and pin_line follows full_lvl
  assign sda_line = sda_rel & (sda_oe ? sda_out : 1'b1);
  assign pin_line = pin_oe ? pin_out : full_lvl;
  bmc_core #(.CONV_CYC(CONV), .IDLE_CYC(IDLE)) bmc_core_inst (
    .mclk(mclk), .nrst(nrst), .ce(ce), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .alert_or_full_pin_in(pin_line), .alert_or_full_pin_out(pin_out),
    .alert_or_full_pin_oe(pin_oe), .volt_code(volt_code), .temp_code(temp_code),
    .charge_up(charge_up), .charge_down(charge_down), .analog_off(analog_off));
  bmc_i2c_master bmc_i2c_master_inst (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic put(input logic [7:0] ptr, input int n, input logic [15:0] d);
    bmc_i2c_master_inst.wr(ptr, n, d);
    tick(6);
  endtask : put
  task automatic get(input logic [7:0] ptr, input int n);
    bmc_i2c_master_inst.rd(ptr, n, rx);
    tick(6);
  endtask : get
  task automatic pulse(input logic up, input logic dn);
    @(posedge mclk);
    charge_up <= up;
    charge_down <= dn;
    @(posedge mclk);
    charge_up <= 1'b0;
    charge_down <= 1'b0;
  endtask : pulse
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    tick(8);
    nrst <= 1'b1;
    tick(60);
    get(8'h00, 16);
    for (int i = 0; i < 16; i++)
      check("reset value", {8'h00, rx[i]}, {8'h00, rows[i]});
    $display("test reset values done");
    put(REG_CONTROL, 1, 16'h0001);
    check("shutdown", {15'h0000, analog_off}, 16'h0001);
    pulse(1'b1, 1'b0);
    put(REG_ACC_HI, 2, 16'h0010);
    put(REG_CONTROL, 1, 16'h0000);
    for (int i = 0; i < 4; i++)
      pulse(i < 3, i == 3);
    get(REG_ACC_HI, 2);
    check("accumulator", {rx[0], rx[1]}, 16'h0012);
    put(REG_CLO_HI, 2, 16'h0020);
    get(REG_STATUS, 1);
    check("charge low flag", {8'h00, rx[0]}, 16'h0004);
    put(REG_CLO_HI, 2, 16'h0000);
    put(REG_STATUS, 1, 16'h00ff);
    get(REG_STATUS, 1);
    check("status clear", {8'h00, rx[0]}, 16'h0000);
    put(REG_VOLT_HI, 2, 16'haa55);
    get(REG_VOLT_HI, 2);
    check("result write", {rx[0], rx[1]}, 16'h0000);
    $display("test accumulator done");
    @(posedge mclk);
    volt_code <= 14'h3000;
    put(REG_VUP, 1, 16'h0080);
    put(REG_CONTROL, 1, 16'h00bc);
    tick(2 * CONV);
    check("alert pin", {15'h0000, pin_oe}, 16'h0001);
    check("alert level", {15'h0000, pin_line}, 16'h0000);
    get(REG_STATUS, 2);
    check("status", {8'h00, rx[0]}, 16'h0002);
    check("mode cleared", {8'h00, rx[1]}, 16'h003c);
    get(REG_VOLT_HI, 2);
    check("voltage", {rx[0], rx[1]}, {volt_code, 2'b00});
    bmc_i2c_master_inst.alert_response_address(b);
    tick(6);
    check("alert reply", {8'h00, b}, {8'h00, DEV_ADDR, 1'b1});
    check("alert release", {15'h0000, pin_oe}, 16'h0000);
    $display("test voltage and alert done");
    @(posedge mclk);
    temp_code <= 10'h2a5;
    put(REG_CONTROL, 1, 16'h007c);
    tick(2 * CONV);
    get(REG_TEMP_HI, 2);
    check("temperature", {rx[0], rx[1]}, {temp_code, 6'b000000});
    @(posedge mclk);
    volt_code <= 14'h1234;
    put(REG_CONTROL, 1, 16'h00fc);
    tick(3 * CONV);
    get(REG_CONTROL, 1);
    check("scan mode", {8'h00, rx[0]}, 16'h00fc);
    get(REG_VOLT_HI, 2);
    check("scan voltage", {rx[0], rx[1]}, {volt_code, 2'b00});
    put(REG_CONTROL, 1, 16'h003a);
    $display("test converter modes done");
    @(posedge mclk);
    full_lvl <= 1'b1;
    tick(8);
    get(REG_ACC_HI, 2);
    check("charge complete", {rx[0], rx[1]}, ACC_FULL);
    @(posedge mclk);
    full_lvl <= 1'b0;
    bmc_i2c_master_inst.start_cond();
    bmc_i2c_master_inst.xfer({DEV_ADDR + 7'h01, 1'b0}, 1'b1, b, k);
    bmc_i2c_master_inst.stop_cond();
    check("foreign address", {15'h0000, k}, 16'h0001);
    @(posedge mclk);
    ce <= 1'b0;
    put(REG_CONTROL, 1, 16'h003b);
    check("frozen by enable", {15'h0000, analog_off}, 16'h0000);
    ce <= 1'b1;
    tick(6);
    check("enable resumes", {15'h0000, analog_off}, 16'h0001);
    $display("test pin role and address done");
    @(posedge mclk);
    nrst <= 1'b0;
    tick(3);
    nrst <= 1'b1;
    tick(6);
    get(8'h00, 4);
    for (int i = 0; i < 4; i++)
      check("second reset", {8'h00, rx[i]}, {8'h00, rows[i]});
    check("acks", {15'h0000, bmc_i2c_master_inst.nak_seen}, 16'h0000);
    $display("test second reset done");
    final_report();
  end
endmodule : bmc_core_test

// *** tb/bmc_i2c_master.sv ***
// Serial bus master model that drives the clock and data lines of the core
`timescale 1ns/1ps
module bmc_i2c_master (
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda_line
);
  localparam logic [6:0] SLAVE = 7'h64;
  // Quarter bit of an 80 ns link period; the clock stands high between frames
  localparam time Q = 20;
  logic nak_seen;
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
    nak_seen = 1'b0;
  end
  task automatic start_cond();
    sda_rel = 1'b1;
    #(Q);
    scl = 1'b1;
    #(2 * Q);
    sda_rel = 1'b0;
    #(2 * Q);
    scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    #(Q);
    sda_rel = 1'b0;
    #(Q);
    scl = 1'b1;
    #(2 * Q);
    sda_rel = 1'b1;
    #(2 * Q);
  endtask : stop_cond
  // Data changes only while the clock is low
  task automatic bit_cyc(input logic tx, output logic rx);
    #(Q);
    sda_rel = tx;
    #(Q);
    scl = 1'b1;
    rx = sda_line;
    #(2 * Q);
    scl = 1'b0;
  endtask : bit_cyc
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_cyc(tx[i], rx[i]);
    bit_cyc(ack_in, ack_out);
  endtask : xfer
  task automatic addr(input logic [6:0] a, input logic rd);
    logic [7:0] r;
    logic       k;
    start_cond();
    xfer({a, rd}, 1'b1, r, k);
    nak_seen = nak_seen | k;
  endtask : addr
  task automatic wr(input logic [7:0] ptr, input int n, input logic [15:0] d);
    logic [7:0] r;
    logic       k;
    addr(SLAVE, 1'b0);
    xfer(ptr, 1'b1, r, k);
    nak_seen = nak_seen | k;
    for (int j = n - 1; j >= 0; j--)
    begin
      xfer(d[8*j +: 8], 1'b1, r, k);
      nak_seen = nak_seen | k;
    end
    stop_cond();
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] d [16]);
    logic [7:0] r;
    logic       k;
    addr(SLAVE, 1'b0);
    xfer(ptr, 1'b1, r, k);
    nak_seen = nak_seen | k;
    addr(SLAVE, 1'b1);
    for (int j = 0; j < n; j++)
      xfer(8'hff, j == n - 1, d[j], k);
    stop_cond();
  endtask : rd
  task automatic alert_response_address(output logic [7:0] d);
    logic k;
    addr(7'h0c, 1'b1);
    xfer(8'hff, 1'b1, d, k);
    stop_cond();
  endtask : alert_response_address
endmodule : bmc_i2c_master
